/* hdl/adc_control_registers.sv */
/*
  control registers and conversion sequencing of a 10-bit converter; result storage and interrupt.
  assumes a core giving one result bit per conversion clock via core_bit_i, msb first.
*/
// Overview of operation
// - reserved channel codes connect no input
// - codes 11110, 11111 route dac, fixed reference
// - writing status bit together with enable bit starts conversion, reads busy
// - hardware clears status bit when done
// - status reads zero when idle
// - enable bit powers converter; clear powers down
// - right justify zeroes high byte msbs
// - left justify zeroes low byte lsbs
// - clock field selects divider or rc
// - negative reference ground or pin
// - left justify: top eight high, two low
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module adc_control_registers
  import adc_ctrl_pkg::*;
#(
  parameter int RC_DIV_P = `RC_DIV
) (
  input  wire logic       clock_i,      // 200 mhz system clock
  input  wire logic       rst_i,        // async reset, high
  input  wire logic       ce_i,         // clock enable, freezes state when low
  input  wire logic [2:0] addr_i,       // register index
  input  wire logic [7:0] wdata_i,      // write data
  input  wire logic       wr_i,         // write strobe
  input  wire logic       rd_i,         // read strobe
  output logic      [7:0] rdata_o,      // read data, cycle after rd_i
  input  wire logic       core_bit_i,   // comparator decision from core, async
  output logic            analog_en_o,  // converter powered
  output logic            input_conn_o, // an input is connected to the core
  output logic      [4:0] mux_sel_o,    // analog mux select
  output logic            sel_dac_o,    // dac output routed
  output logic            sel_fixed_o,  // fixed reference routed
  output logic            sample_o,     // core converting
  output logic            core_clk_o,   // conversion clock tick
  output logic            nref_pin_o,   // negative ref from pin
  output logic      [1:0] pref_sel_o,   // positive ref select
  output logic            irq_o         // level interrupt
);
  logic [7:0]     ctrl0_ff;
  logic [7:0]     ctrl1_ff;
  logic [7:0]     res_high_ff;
  logic [7:0]     res_low_ff;
  logic [7:0]     rdata_ff;
  logic           done_sts_ff;
  logic           mask_ff;
  logic [9:0]     shift_ff;
  logic [3:0]     bit_cnt_ff;
  logic [15:0]    rc_cnt_ff;
  conv_state_type state_ff;
  conv_state_type nxt_state;

  wire [4:0] chan      = ctrl0_ff[6:2];
  wire       enabled   = ctrl0_ff[`CTRL0_ENABLE_BIT];
  wire       justify_r = ctrl1_ff[`CTRL1_JUSTIFY_BIT];
  wire [2:0] clk_sel   = ctrl1_ff[6:4];
  wire       sel_wr0   = wr_i && addr_i == `CTRL0_OFS;
  wire       sel_wr1   = wr_i && addr_i == `CTRL1_OFS;
  wire       sel_wrm   = wr_i && addr_i == `IRQ_MASK_OFS;
  wire       sel_rdst  = rd_i && addr_i == `IRQ_STATUS_OFS;
  wire       start     = sel_wr0 && wdata_i[`CTRL0_STATUS_BIT] && wdata_i[`CTRL0_ENABLE_BIT];
  wire       busy      = state_ff != conv_idle_type_v;
  wire       rc_tick   = rc_cnt_ff == 16'((RC_DIV_P - 1));
  wire       tick;
  wire       core_bit;
  wire       finish    = state_ff == conv_store_type_v;
  wire [7:0] nxt_high  = justify_r ? {6'h00, shift_ff[9:8]} : shift_ff[9:2];
  wire [7:0] nxt_low   = justify_r ? shift_ff[7:0] : {shift_ff[1:0], 6'h00};

  sync3 u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .d_i     (core_bit_i),
    .q_o     (core_bit)
  );

  conv_clock_gen u_clk (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .run_i     (busy && enabled),
    .sel_i     (clk_sel),
    .rc_tick_i (rc_tick),
    .tick_o    (tick)
  );

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      conv_idle_type_v:  if (start) nxt_state = conv_run_type_v;
      conv_run_type_v: begin
        if (!enabled) nxt_state = conv_idle_type_v;
        else if (tick && bit_cnt_ff == 4'(`BIT_PERIODS - 1)) nxt_state = conv_store_type_v;
      end
      conv_store_type_v: nxt_state = conv_idle_type_v;
      default:           nxt_state = conv_idle_type_v;
    endcase
  end

  // free-running stand-in for the dedicated rc oscillator
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rc_cnt_ff <= 16'h0000;
    end else if (ce_i) begin
      rc_cnt_ff <= rc_tick ? 16'h0000 : rc_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff   <= conv_idle_type_v;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 10'h000;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      if (start && !busy) begin
        bit_cnt_ff <= 4'h0;
      end else if (tick) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (bit_cnt_ff != 4'h0) begin
          shift_ff <= {shift_ff[8:0], core_bit};
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl0_ff <= `CTRL0_RESET;
      ctrl1_ff <= `CTRL1_RESET;
      mask_ff  <= 1'b0;
    end else if (ce_i) begin
      if (sel_wr0) begin
        ctrl0_ff[6:2] <= wdata_i[6:2];
        ctrl0_ff[0]   <= wdata_i[0];
      end
      if (sel_wr1) begin
        ctrl1_ff <= {wdata_i[7:4], 1'b0, wdata_i[2:0]};
      end
      if (sel_wrm) begin
        mask_ff <= wdata_i[0];
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      res_high_ff <= 8'h00;
      res_low_ff  <= 8'h00;
      done_sts_ff <= 1'b0;
    end else if (ce_i) begin
      if (finish) begin
        res_high_ff <= nxt_high;
        res_low_ff  <= nxt_low;
      end
      // set wins over the read clear
      done_sts_ff <= finish || (done_sts_ff && !sel_rdst);
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr_i)
      `CTRL0_OFS:      rd_mux = {1'b0, chan, busy, enabled};
      `CTRL1_OFS:      rd_mux = ctrl1_ff;
      `RES_HIGH_OFS:   rd_mux = res_high_ff;
      `RES_LOW_OFS:    rd_mux = res_low_ff;
      `IRQ_STATUS_OFS: rd_mux = {7'h00, done_sts_ff};
      `IRQ_MASK_OFS:   rd_mux = {7'h00, mask_ff};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else if (ce_i) begin
      rdata_ff <= rd_i ? rd_mux : 8'h00;
    end
  end

  wire reserved_ch = chan >= `CHAN_RSV_LO && chan <= `CHAN_RSV_HI;

  assign rdata_o      = rdata_ff;
  assign analog_en_o  = enabled;
  assign input_conn_o = enabled && !reserved_ch;
  assign mux_sel_o    = chan;
  assign sel_dac_o    = enabled && chan == `CHAN_DAC;
  assign sel_fixed_o  = enabled && chan == `CHAN_FIXED_REF;
  assign sample_o     = busy;
  assign core_clk_o   = tick;
  assign nref_pin_o   = ctrl1_ff[`CTRL1_NREF_BIT];
  assign pref_sel_o   = ctrl1_ff[1:0];
  assign irq_o        = done_sts_ff && mask_ff;

  chk_busy_clears: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && finish |=> !busy)
    else $error("status bit not cleared after store");
  chk_start_busy: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && start && !busy |=> busy)
    else $error("start did not begin a conversion");
  chk_idle_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == `CTRL0_OFS && !busy |=> !rdata_o[1])
    else $error("status reads one while idle");
  chk_reserved_off: assert property (@(posedge clock_i) disable iff (rst_i)
    reserved_ch |-> !input_conn_o && !sel_dac_o && !sel_fixed_o)
    else $error("reserved code connected an input");
  chk_dac_route: assert property (@(posedge clock_i) disable iff (rst_i)
    enabled && chan == 5'h1e |-> sel_dac_o && !sel_fixed_o)
    else $error("dac not routed");
  chk_power_down: assert property (@(posedge clock_i) disable iff (rst_i)
    !enabled |-> !analog_en_o && !input_conn_o)
    else $error("converter powered while disabled");
  chk_right_just: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && finish && justify_r |=> res_high_ff[7:2] == 6'h00)
    else $error("right justify msbs not zero");
  chk_left_just: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && finish && !justify_r |=> res_low_ff[5:0] == 6'h00 && res_high_ff == $past(shift_ff[9:2]))
    else $error("left justify layout wrong");
  chk_nref_sel: assert property (@(posedge clock_i) disable iff (rst_i)
    nref_pin_o == ctrl1_ff[2])
    else $error("negative reference mismatch");
  chk_div2_tick: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && tick && clk_sel == 3'b000 && busy && enabled ##1 ce_i && busy && enabled |-> !tick)
    else $error("div2 tick spacing wrong");

  // conversion clock seen from outside the divider: ticks per run and cycles between ticks
  logic [15:0] gap_ff;
  logic        seen_ff;
  logic [3:0]  tick_cnt_ff;
  logic [15:0] exp_gap;
  wire         gap_clear = !(busy && enabled) || sel_wr1;

  always_comb begin
    unique case (clk_sel)
      3'b000:         exp_gap = 16'h0002;
      3'b001:         exp_gap = 16'h0008;
      3'b010:         exp_gap = 16'h0020;
      3'b100:         exp_gap = 16'h0004;
      3'b101:         exp_gap = 16'h0010;
      3'b110:         exp_gap = 16'h0040;
      3'b011, 3'b111: exp_gap = 16'(RC_DIV_P);
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gap_ff  <= 16'h0000;
      seen_ff <= 1'b0;
    end else if (ce_i) begin
      if (gap_clear) begin
        gap_ff  <= 16'h0000;
        seen_ff <= 1'b0;
      end else if (tick) begin
        gap_ff  <= 16'h0001;
        seen_ff <= 1'b1;
      end else begin
        gap_ff <= gap_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_ff <= 4'h0;
    end else if (ce_i) begin
      if (start && !busy) begin
        tick_cnt_ff <= 4'h0;
      end else if (tick && state_ff == conv_run_type_v) begin
        tick_cnt_ff <= tick_cnt_ff + 4'h1;
      end
    end
  end

  chk_fixed_route: assert property (@(posedge clock_i) disable iff (rst_i)
    enabled && chan == `CHAN_FIXED_REF |-> sel_fixed_o && !sel_dac_o && input_conn_o)
    else $error("fixed reference not routed");
  chk_normal_conn: assert property (@(posedge clock_i) disable iff (rst_i)
    enabled && chan < `CHAN_RSV_LO |-> input_conn_o && !sel_dac_o && !sel_fixed_o)
    else $error("ordinary channel not connected");
  chk_start_disabled: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && sel_wr0 && !wdata_i[`CTRL0_ENABLE_BIT] && !busy |=> !busy)
    else $error("conversion started while disabled");
  chk_abort_clean: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && state_ff == conv_run_type_v && !enabled |=> !busy && $stable(res_high_ff) && $stable(res_low_ff))
    else $error("disabled conversion kept running or stored");
  chk_done_set: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && finish |=> done_sts_ff)
    else $error("done status not set");
  chk_status_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && sel_rdst && !finish |=> !done_sts_ff)
    else $error("done status not cleared by read");
  chk_irq_set: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && finish && mask_ff && !sel_wrm |=> irq_o)
    else $error("unmasked done gave no interrupt");
  chk_right_layout: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && finish && justify_r |=> {res_high_ff[1:0], res_low_ff} == $past(shift_ff))
    else $error("right justified result misplaced");
  chk_left_layout: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && finish && !justify_r |=> {res_high_ff, res_low_ff[7:6]} == $past(shift_ff))
    else $error("left justified result misplaced");
  chk_ctrl1_write: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && sel_wr1 |=> ctrl1_ff == ($past(wdata_i) & 8'hf7) && {nref_pin_o, pref_sel_o} == ctrl1_ff[2:0])
    else $error("control one write not applied");
  chk_no_idle_tick: assert property (@(posedge clock_i) disable iff (rst_i)
    !busy |-> !core_clk_o)
    else $error("conversion clock while idle");
  chk_tick_gap: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && tick && seen_ff |-> gap_ff == exp_gap)
    else $error("conversion clock period wrong");
  chk_tick_count: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && finish |-> tick_cnt_ff == 4'(`BIT_PERIODS))
    else $error("conversion ended after wrong tick count");
  chk_rdata_idle: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data without read strobe");
  chk_status_live: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == `CTRL0_OFS && busy |=> rdata_o[`CTRL0_STATUS_BIT])
    else $error("status reads zero while busy");
  chk_busy_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && state_ff == conv_run_type_v && enabled |=> busy)
    else $error("conversion dropped early");
  chk_ctrl0_msb: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == `CTRL0_OFS |=> !rdata_o[7])
    else $error("unused control bit reads one");
  chk_ctrl0_write: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && sel_wr0 |=> {1'b0, mux_sel_o, 1'b0, analog_en_o} == ($past(wdata_i) & 8'h7d))
    else $error("control zero write not applied");
  chk_mask_write: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && sel_wrm |=> mask_ff == |($past(wdata_i) & 8'h01))
    else $error("mask write not applied");
  chk_unmapped_wr: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && wr_i && addr_i > `IRQ_MASK_OFS |=> $stable(ctrl1_ff) && $stable(mask_ff))
    else $error("unmapped write changed a register");

  cov_conversion: cover property (@(posedge clock_i) disable iff (rst_i) start ##[1:400] finish);
  cov_irq:        cover property (@(posedge clock_i) disable iff (rst_i) irq_o);
  cov_abort:      cover property (@(posedge clock_i) disable iff (rst_i) busy && !enabled);
  cov_right:      cover property (@(posedge clock_i) disable iff (rst_i) finish && justify_r);
  cov_rc_gap:     cover property (@(posedge clock_i) disable iff (rst_i) tick && seen_ff && clk_sel[1:0] == 2'b11);
endmodule

/* include/adc_ctrl_map.svh */
/*
  register offsets, field positions, reset values and timing counts of the converter control block.
  assumes inclusion by bare name from the two modules; the package does not include it.
*/
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define CTRL0_OFS         3'h0
`define CTRL1_OFS         3'h1
`define RES_HIGH_OFS      3'h2
`define RES_LOW_OFS       3'h3
`define IRQ_STATUS_OFS    3'h4
`define IRQ_MASK_OFS      3'h5

`define CTRL0_RESET       8'h00
`define CTRL1_RESET       8'h00

`define CTRL0_ENABLE_BIT  0
`define CTRL0_STATUS_BIT  1
`define CTRL0_CHAN_LSB    2
`define CTRL1_JUSTIFY_BIT 7
`define CTRL1_CLK_LSB     4
`define CTRL1_NREF_BIT    2
`define CTRL1_PREF_LSB    0

`define CHAN_RSV_LO       5'h0e
`define CHAN_RSV_HI       5'h1d
`define CHAN_DAC          5'h1e
`define CHAN_FIXED_REF    5'h1f

`define RC_PERIOD_NS      4000
`define CLOCK_PERIOD_NS   5
`define RC_DIV            (`RC_PERIOD_NS / `CLOCK_PERIOD_NS)
`define BIT_PERIODS       11

`endif

/* include/adc_ctrl_pkg.sv */
/*
  types shared by the converter control block.
  assumes adc_ctrl_map.svh on the include path.
*/
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    conv_idle_type_v  = 2'b00,
    conv_run_type_v   = 2'b01,
    conv_store_type_v = 2'b10
  } conv_state_type;

  typedef enum logic [1:0] {
    pref_supply   = 2'b00,
    pref_reserved = 2'b01,
    pref_pin      = 2'b10,
    pref_fixed    = 2'b11
  } pos_ref_type;
endpackage

/* hdl/conv_clock_gen.sv */
/*
  conversion clock tick generator: divides the system clock or passes the rc tick per select code.
  assumes rc_tick_i is already synchronous to clock_i.
*/
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module conv_clock_gen
  import adc_ctrl_pkg::*;
(
  input  wire logic       clock_i,   // system clock
  input  wire logic       rst_i,     // async reset, high
  input  wire logic       ce_i,      // clock enable
  input  wire logic       run_i,     // count only while converting
  input  wire logic [2:0] sel_i,     // conversion clock select
  input  wire logic       rc_tick_i, // synchronised rc tick
  output logic            tick_o     // one conversion clock period elapsed
);
  logic [5:0] div_ff;
  logic [5:0] nxt_div;
  logic [5:0] limit;
  logic       use_rc;

  always_comb begin
    use_rc = 1'b0;
    unique case (sel_i)
      3'b000: limit = 6'h01;
      3'b001: limit = 6'h07;
      3'b010: limit = 6'h1f;
      3'b100: limit = 6'h03;
      3'b101: limit = 6'h0f;
      3'b110: limit = 6'h3f;
      3'b011, 3'b111: begin
        limit  = 6'h00;
        use_rc = 1'b1;
      end
    endcase
  end

  assign nxt_div = (!run_i || div_ff == limit) ? 6'h00 : div_ff + 6'h01;
  assign tick_o  = run_i && (use_rc ? rc_tick_i : (div_ff == limit));

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_ff <= 6'h00;
    end else if (ce_i) begin
      div_ff <= nxt_div;
    end
  end
endmodule

/* hdl/sync3.sv */
/*
  three-flop synchroniser; output changes once stages two and three agree.
  assumes async input from outside clock domain.
*/
`timescale 1ns/1ps
module sync3 (
  input  wire logic clock_i, // system clock
  input  wire logic rst_i,   // async reset, high
  input  wire logic ce_i,    // clock enable
  input  wire logic d_i,     // async input
  output logic      q_o      // filtered level
);
  logic [2:0] stage_ff;
  logic       q_ff;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stage_ff <= 3'h0;
      q_ff     <= 1'b0;
    end else if (ce_i) begin
      stage_ff <= {stage_ff[1:0], d_i};
      if (stage_ff[1] == stage_ff[2]) begin
        q_ff <= stage_ff[2];
      end
    end
  end
  assign q_o = q_ff;
endmodule

/* tb/core_partner.sv */
/*
  far-side model: converter core returning a target value msb first, whatever the channel.
  assumes one tick_i pulse per conversion clock, the first one spent on sampling.
*/
`timescale 1ns/1ps
module core_partner (
  input  wire logic       clock_i,  // system clock
  input  wire logic       rst_i,    // async reset, high
  input  wire logic       sample_i, // conversion running
  input  wire logic       tick_i,   // conversion clock tick
  input  wire logic [9:0] target_i, // value to return
  output logic            bit_o     // comparator decision
);
  logic [3:0] idx_ff;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      idx_ff <= 4'h0;
      bit_o  <= 1'b0;
    end else if (!sample_i) begin
      // idle line wanders so a stale level is never taken for data
      idx_ff <= 4'h0;
      bit_o  <= ~bit_o;
    end else if (tick_i && idx_ff < 4'ha) begin
      bit_o  <= target_i[4'h9 - idx_ff];
      idx_ff <= idx_ff + 4'h1;
    end
  end
endmodule

/* tb/adc_control_registers_bench.sv */
/*
  self-checking bench of the converter control block with a core model.
  assumes a 200 mhz clock and a shortened rc divider.
*/
`timescale 1ns/1ps
module adc_control_registers_bench;
  localparam int RC_N = 8;
  logic       clock_i = 1'b0;
  logic       rst_i   = 1'b1;
  logic [2:0] addr_i  = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i    = 1'b0;
  logic       rd_i    = 1'b0;
  logic       rd_q    = 1'b0;
  logic [7:0] rdata_o;
  logic       core_bit_i, analog_en_o, input_conn_o, sel_dac_o, sel_fixed_o;
  logic       sample_o, core_clk_o, nref_pin_o, irq_o;
  logic [4:0] mux_sel_o;
  logic [1:0] pref_sel_o;
  logic [9:0] target  = 10'h000;
  logic [7:0] c1;
  logic [4:0] ch;
  logic [7:0] exp_q[$];
  int         div_t[8] = '{2, 8, 32, RC_N, 4, 16, 64, RC_N};
  int         error_cnt = 0;
  int         check_count = 0;
  int         seed = 33206;
  int         n;

  always #2.5 clock_i = ~clock_i;

  adc_control_registers #(.RC_DIV_P(RC_N)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .core_bit_i(core_bit_i),
    .analog_en_o(analog_en_o), .input_conn_o(input_conn_o), .mux_sel_o(mux_sel_o),
    .sel_dac_o(sel_dac_o), .sel_fixed_o(sel_fixed_o), .sample_o(sample_o),
    .core_clk_o(core_clk_o), .nref_pin_o(nref_pin_o), .pref_sel_o(pref_sel_o), .irq_o(irq_o));

  core_partner model (.clock_i(clock_i), .rst_i(rst_i), .sample_i(sample_o), .tick_i(core_clk_o),
    .target_i(target), .bit_o(core_bit_i));

  task automatic conclude;
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one strobe cycle; a read notes its expected data for the monitor
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i    <= w;
    rd_i    <= ~w;
    addr_i  <= a;
    wdata_i <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask

  task automatic settle;
    @(posedge clock_i);
    #1;
  endtask

  // tick: wait for a conversion clock pulse, else for the end of conversion
  task automatic waitc(input logic tick);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while ((tick ? core_clk_o : ~sample_o) !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      conclude();
    end
  endtask

  always @(posedge clock_i) begin
    rd_q <= rd_i;
    if (rd_q) chk(rdata_o, exp_q.pop_front());
  end

  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) bus(1'b0, 3'(a), 8'h00);
    bus(1'b1, 3'h1, 8'hff);
    bus(1'b0, 3'h1, 8'hf7);
    bus(1'b1, 3'h6, 8'hff);
    bus(1'b0, 3'h6, 8'h00);
    bus(1'b1, 3'h0, 8'hfd);
    bus(1'b0, 3'h0, 8'h7d);
    bus(1'b1, 3'h0, 8'h06);
    settle();
    chk(sample_o, 1'b0);
    bus(1'b0, 3'h0, 8'h04);
    for (int c = 0; c < 32; c++) begin
      ch = 5'(c);
      bus(1'b1, 3'h0, {1'b0, ch, 2'b01});
      settle();
      chk({analog_en_o, mux_sel_o}, {1'b1, ch});
      chk(input_conn_o, ch < 5'h0e || ch > 5'h1d);
      chk({sel_dac_o, sel_fixed_o}, {ch == 5'h1e, ch == 5'h1f});
      bus(1'b1, 3'h0, {1'b0, ch, 2'b00});
      settle();
      chk({analog_en_o, input_conn_o, sel_dac_o, sel_fixed_o}, 4'h0);
    end
    for (int k = 0; k < 8; k++) begin
      c1 = 8'($random(seed));
      c1[6:4] = 3'(k);
      c1[3] = 1'b0;
      target = 10'($random(seed));
      ch = 5'($unsigned($random(seed)) % 14);
      bus(1'b1, 3'h1, c1);
      bus(1'b0, 3'h1, c1);
      settle();
      chk({nref_pin_o, pref_sel_o}, c1[2:0]);
      bus(1'b1, 3'h5, {7'h00, k[0]});
      bus(1'b1, 3'h0, {1'b0, ch, 2'b11});
      bus(1'b0, 3'h0, {1'b0, ch, 2'b11});
      waitc(1'b1);
      waitc(1'b1);
      chk(10'(n), 10'(div_t[k]));
      waitc(1'b0);
      settle();
      chk(irq_o, k[0]);
      bus(1'b0, 3'h0, {1'b0, ch, 2'b01});
      // the core model needs a few cycles to cross the synchroniser
      if (div_t[k] >= 8) begin
        bus(1'b0, 3'h2, c1[7] ? {6'h00, target[9:8]} : target[9:2]);
        bus(1'b0, 3'h3, c1[7] ? target[7:0] : {target[1:0], 6'h00});
      end
      bus(1'b0, 3'h4, 8'h01);
      settle();
      chk(irq_o, 1'b0);
    end
    // clearing the enable bit mid-conversion aborts without a result
    bus(1'b1, 3'h1, 8'h60);
    bus(1'b1, 3'h0, 8'h07);
    bus(1'b1, 3'h0, 8'h04);
    settle();
    chk({sample_o, analog_en_o, irq_o}, 3'h0);
    bus(1'b0, 3'h4, 8'h00);
    bus(1'b0, 3'h0, 8'h04);
    repeat (3) @(posedge clock_i);
    conclude();
  end
endmodule
